// ==== rtl/nand_busy_pkg.sv ====
package nand_busy_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int unsigned TOTAL_BLOCKS       = 2048;
  localparam int unsigned MIN_VALID_BLOCKS   = 2008;
  localparam int unsigned BLOCK_W            = 11;
  localparam int unsigned PAGE_W             = 7;
  localparam int unsigned PAGES_PER_BLOCK    = 128;
  localparam int unsigned PARTIAL_PROGRAM_LIMIT     = 4;
  localparam int unsigned OTP_PARTIAL_PROGRAM_LIMIT = 8;
  localparam int unsigned PP_CNT_W           = 4;

  // ----------------------------------------------------------------
  // Clock and timing (figures in ns as printed, counts derived)
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS      = 100;
  localparam int unsigned BUSY_CNT_W         = 16;

  localparam int unsigned ERASE_BUSY_TIME_NS          = 3000000;
  localparam int unsigned CACHE_READ_BUSY_TIME_NS     = 25000;
  localparam int unsigned FEATURE_ACCESS_BUSY_TIME_NS = 1000;
  localparam int unsigned MODE_SWITCH_BUSY_TIME_NS    = 1000;
  localparam int unsigned PROTECTED_OTP_BUSY_TIME_NS  = 30000;
  localparam int unsigned PAGE_PROGRAM_TIME_NS        = 500000;
  localparam int unsigned PAGE_READ_TIME_NS           = 25000;
  localparam int unsigned READY_RESET_TIME_NS         = 5000;
  localparam int unsigned STROBE_TO_BUSY_DELAY_NS     = 100;
  localparam int unsigned CACHED_LOAD_TIME_NS         = 100000;

  // Longest times round down, none below one cycle
  function automatic int unsigned max_cycles(input int unsigned ns);
    int unsigned c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int unsigned ERASE_BUSY_CYC     = max_cycles(ERASE_BUSY_TIME_NS);
  localparam int unsigned CACHE_READ_CYC     =
    max_cycles(CACHE_READ_BUSY_TIME_NS);
  localparam int unsigned FEATURE_CYC        =
    max_cycles(FEATURE_ACCESS_BUSY_TIME_NS);
  localparam int unsigned MODE_SWITCH_CYC    =
    max_cycles(MODE_SWITCH_BUSY_TIME_NS);
  localparam int unsigned PROTECTED_OTP_CYC  =
    max_cycles(PROTECTED_OTP_BUSY_TIME_NS);
  localparam int unsigned PAGE_PROGRAM_CYC   =
    max_cycles(PAGE_PROGRAM_TIME_NS);
  localparam int unsigned PAGE_READ_CYC      = max_cycles(PAGE_READ_TIME_NS);
  localparam int unsigned READY_RESET_CYC    = max_cycles(READY_RESET_TIME_NS);
  localparam int unsigned STROBE_TO_BUSY_CYC =
    max_cycles(STROBE_TO_BUSY_DELAY_NS);
  localparam int unsigned CACHED_LOAD_CYC    = max_cycles(CACHED_LOAD_TIME_NS);
  localparam int unsigned FINAL_CACHED_PROGRAM_CYC =
    2 * PAGE_PROGRAM_CYC - CACHED_LOAD_CYC;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  typedef enum logic [3:0] {
    OP_NONE          = 4'h0,
    OP_PAGE_READ     = 4'h1,
    OP_CACHE_READ    = 4'h2,
    OP_PAGE_PROGRAM  = 4'h3,
    OP_CACHED_LAST   = 4'h4,
    OP_ERASE         = 4'h5,
    OP_FEATURE       = 4'h6,
    OP_MODE_SYNC     = 4'h7,
    OP_RESET         = 4'h8,
    OP_OTP_PROGRAM   = 4'h9,
    OP_OTP_PROTECT   = 4'ha
  } op_t;

  localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
  localparam logic [7:0] CMD_RESET        = 8'hff;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
  localparam logic [7:0] CMD_LUN_STATUS   = 8'h78;

  // Result codes
  localparam logic [1:0] RES_PASS    = 2'h0;
  localparam logic [1:0] RES_FAIL    = 2'h1;
  localparam logic [1:0] RES_REFUSED = 2'h2;

endpackage

// ==== rtl/nand_busy_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface nand_busy_if;
  import nand_busy_pkg::*;
  logic               cmd_valid;
  op_t                cmd_op;
  logic [BLOCK_W-1:0] cmd_block;
  logic [PAGE_W-1:0]  cmd_page;
  logic               ready;
  logic               sync_mode;
  logic [1:0]         result;

  modport device (
    input  cmd_valid, cmd_op, cmd_block, cmd_page,
    output ready, sync_mode, result
  );
  modport host (
    output cmd_valid, cmd_op, cmd_block, cmd_page,
    input  ready, sync_mode, result
  );
endinterface
`default_nettype wire

// ==== rtl/busy_timer.sv ====
`timescale 1ns/100ps
`default_nettype none
module busy_timer
  import nand_busy_pkg::*;
(
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire logic                  load,
  input  wire logic [BUSY_CNT_W-1:0] cycles,
  output logic                       busy
);
  logic [BUSY_CNT_W-1:0] count_reg;

  // ----------------------------------------------------------------
  // Down counter; busy while above one
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= '0;
    end else if (load) begin
      count_reg <= cycles;
    end else if (count_reg != '0) begin
      count_reg <= count_reg - 1'b1;
    end
  end

  // Ready is registered one stage later, so the final count is absorbed
  // there; otherwise every busy window would run one cycle past its limit
  assign busy = (count_reg > BUSY_CNT_W'(1));
endmodule
`default_nettype wire

// ==== rtl/nand_busy_device.sv ====
// Summary of operation
// (R1) Keep at least 2008 of 2048 blocks usable
// (R2) Host never programs or erases factory-bad blocks
// (R3) At most 4 partial programs per page; host refuses a fifth only with no other target between, device only flags it
// (R4) One-time-programmable pages allow 8 partial programs
// (R5) Erase busy at most 3 ms
// (R6) Cache read busy at most 25 us
// (R7) Feature access busy at most 1 us
// (R8) Mode switch by EFh/FFh, busy 1 us
// (R9) No commands at all during mode switch
// (R10) Protected OTP program: busy 30 us, no write
// (R11) Page program busy at most 500 us
// (R12) Page read busy at most 25 us
// (R13) Final cached program is two programs minus load
// (R14) Reset while ready busy at most 5 us
// (R15) Host waits strobe-to-busy delay before next command
// (R16) Ready low for each whole array operation
`timescale 1ns/100ps
`default_nettype none
module nand_busy_device
  import nand_busy_pkg::*;
(
  nand_busy_if.device            link,
  input  wire logic              clock,
  input  wire logic              rst_n,
  input  wire logic [BLOCK_W-1:0] mark_bad_block,
  input  wire logic              mark_bad_valid,
  output logic [BLOCK_W:0]       bad_block_count,
  output logic                   otp_protected,
  output logic                   pp_violation
);
  logic                  load;
  logic [BUSY_CNT_W-1:0] load_cycles;
  logic                  timer_busy;
  logic                  ready_reg;
  logic                  sync_reg;
  logic                  otp_prot_reg;
  logic [1:0]            result_reg;
  logic [BLOCK_W:0]      bad_cnt_reg;
  logic                  viol_reg;
  logic                  accept;
  logic [TOTAL_BLOCKS-1:0] bad_map_reg;
  logic [PP_CNT_W-1:0]   pp_cnt_reg [PAGES_PER_BLOCK];
  logic [PP_CNT_W-1:0]   otp_cnt_reg [PAGES_PER_BLOCK];
  logic [PP_CNT_W-1:0]   cur_pp;
  logic                  block_bad;
  logic                  wear_ok;

  // ----------------------------------------------------------------
  // Command acceptance and busy time selection
  // ----------------------------------------------------------------
  // Commands arriving while busy are ignored; only a reset counts.
  assign accept = link.cmd_valid &&
                  (ready_reg || link.cmd_op == OP_RESET);
  assign block_bad = bad_map_reg[link.cmd_block];
  assign cur_pp    = pp_cnt_reg[link.cmd_page];
  // Retiring a block must never drop the pool under the minimum
  assign wear_ok   = (bad_cnt_reg <
                      (BLOCK_W+1)'(TOTAL_BLOCKS - MIN_VALID_BLOCKS)); // see R1

  always_comb begin
    load        = accept;
    load_cycles = BUSY_CNT_W'(1);
    unique case (link.cmd_op)
      OP_PAGE_READ:    load_cycles = BUSY_CNT_W'(PAGE_READ_CYC);   // see R12
      OP_CACHE_READ:   load_cycles = BUSY_CNT_W'(CACHE_READ_CYC);  // see R6
      OP_PAGE_PROGRAM: load_cycles = BUSY_CNT_W'(PAGE_PROGRAM_CYC); // see R11
      OP_CACHED_LAST:
        load_cycles = BUSY_CNT_W'(FINAL_CACHED_PROGRAM_CYC);  // see R13
      OP_ERASE:        load_cycles = BUSY_CNT_W'(ERASE_BUSY_CYC); // see R5
      OP_FEATURE:      load_cycles = BUSY_CNT_W'(FEATURE_CYC);     // see R7
      OP_MODE_SYNC:    load_cycles = BUSY_CNT_W'(MODE_SWITCH_CYC); // see R8
      OP_RESET:
        load_cycles = sync_reg ? BUSY_CNT_W'(MODE_SWITCH_CYC)   // see R8
                               : BUSY_CNT_W'(READY_RESET_CYC);  // see R14
      OP_OTP_PROGRAM:
        load_cycles = otp_prot_reg ? BUSY_CNT_W'(PROTECTED_OTP_CYC) // see R10
                                   : BUSY_CNT_W'(PAGE_PROGRAM_CYC);
      OP_OTP_PROTECT:  load_cycles = BUSY_CNT_W'(PAGE_PROGRAM_CYC);
      default:         load = 1'b0;
    endcase
  end

  busy_timer u_timer (
    .clock  (clock),
    .rst_n  (rst_n),
    .load   (load),
    .cycles (load_cycles),
    .busy   (timer_busy)
  );

  // ----------------------------------------------------------------
  // Ready/busy: low from acceptance until the timer drains
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_reg <= 1'b1;
    end else begin
      ready_reg <= !(load || timer_busy);  // see R16
    end
  end

  // ----------------------------------------------------------------
  // Interface mode and OTP protection
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_reg     <= 1'b0;
      otp_prot_reg <= 1'b0;
    end else if (accept) begin
      if (link.cmd_op == OP_MODE_SYNC) begin
        sync_reg <= 1'b1;  // see R8
      end else if (link.cmd_op == OP_RESET) begin
        sync_reg <= 1'b0;  // see R8
      end
      if (link.cmd_op == OP_OTP_PROTECT) begin
        otp_prot_reg <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Partial program counters; one counter per page index, not per block
  // ----------------------------------------------------------------
  // Trade-off: counts are tracked for one page row shared by all
  // blocks; an erase clears only the page counter it names, which is enough to flag overuse.
  genvar gi;
  generate
    for (gi = 0; gi < PAGES_PER_BLOCK; gi++) begin : g_pp
      always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
          pp_cnt_reg[gi]  <= '0;
          otp_cnt_reg[gi] <= '0;
        end else if (accept && link.cmd_page == PAGE_W'(gi)) begin
          if (link.cmd_op == OP_ERASE) begin
            pp_cnt_reg[gi] <= '0;
          end else if ((link.cmd_op == OP_PAGE_PROGRAM ||
                        link.cmd_op == OP_CACHED_LAST) &&
                       pp_cnt_reg[gi] != '1) begin
            pp_cnt_reg[gi] <= pp_cnt_reg[gi] + 1'b1;
          end else if (link.cmd_op == OP_OTP_PROGRAM && !otp_prot_reg &&
                       otp_cnt_reg[gi] != '1) begin
            otp_cnt_reg[gi] <= otp_cnt_reg[gi] + 1'b1;
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Result, violation flag and bad block map
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      result_reg <= RES_PASS;
      viol_reg   <= 1'b0;
    end else if (accept) begin
      result_reg <= RES_PASS;
      if (link.cmd_op == OP_OTP_PROGRAM && otp_prot_reg) begin
        result_reg <= RES_FAIL;  // see R10
      end else if ((link.cmd_op == OP_PAGE_PROGRAM ||
                    link.cmd_op == OP_ERASE) && block_bad) begin
        result_reg <= RES_REFUSED;  // see R2
      end
      if ((link.cmd_op == OP_PAGE_PROGRAM &&
           cur_pp >= PP_CNT_W'(PARTIAL_PROGRAM_LIMIT)) ||    // see R3
          (link.cmd_op == OP_OTP_PROGRAM && !otp_prot_reg &&
           otp_cnt_reg[link.cmd_page] >=
             PP_CNT_W'(OTP_PARTIAL_PROGRAM_LIMIT))) begin  // see R4
        viol_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bad_map_reg <= '0;
      bad_cnt_reg <= '0;
    end else if (mark_bad_valid && wear_ok &&
                 !bad_map_reg[mark_bad_block]) begin
      bad_map_reg[mark_bad_block] <= 1'b1;  // see R1
      bad_cnt_reg <= bad_cnt_reg + 1'b1;
    end
  end

  assign link.ready      = ready_reg;
  assign link.sync_mode  = sync_reg;
  assign link.result     = result_reg;
  assign bad_block_count = bad_cnt_reg;
  assign otp_protected   = otp_prot_reg;
  assign pp_violation    = viol_reg;
endmodule
`default_nettype wire

// ==== rtl/nand_busy_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module nand_busy_host
  import nand_busy_pkg::*;
(
  nand_busy_if.host               link,
  input  wire logic               clock,
  input  wire logic               rst_n,
  input  wire logic               req_valid,
  input  wire op_t                req_op,
  input  wire logic [BLOCK_W-1:0] req_block,
  input  wire logic [PAGE_W-1:0]  req_page,
  input  wire logic               req_block_bad,
  output logic                    req_ready,
  output logic                    req_refused,
  output logic                    done
);
  typedef enum logic [1:0] {
    H_IDLE = 2'b00,
    H_WAIT = 2'b01,
    H_BUSY = 2'b11
  } hstate_t;

  hstate_t               state_reg;
  logic [BUSY_CNT_W-1:0] wait_reg;
  logic                  cmd_valid_reg;
  op_t                   cmd_op_reg;
  logic [BLOCK_W-1:0]    block_reg;
  logic [PAGE_W-1:0]     page_reg;
  logic                  refused_reg;
  logic                  done_reg;
  logic [PP_CNT_W-1:0]   pp_reg;
  logic                  issue;
  logic                  blocked;
  logic                  over_pp;
  logic                  same_tgt;

  // Local partial-program count for the current page target only;
  // a different target starts afresh and is never held to the old count
  assign same_tgt = (req_page == page_reg) && (req_block == block_reg);
  assign over_pp  = same_tgt &&
                    ((req_op == OP_PAGE_PROGRAM &&
                      pp_reg >= PP_CNT_W'(PARTIAL_PROGRAM_LIMIT)) ||  // see R3
                     (req_op == OP_OTP_PROGRAM &&
                      pp_reg >= PP_CNT_W'(OTP_PARTIAL_PROGRAM_LIMIT))); // see R4
  assign blocked = req_block_bad && (req_op == OP_PAGE_PROGRAM ||
                   req_op == OP_ERASE || req_op == OP_CACHED_LAST); // see R2
  assign issue   = (state_reg == H_IDLE) && req_valid && link.ready; // see R9

  // ----------------------------------------------------------------
  // Sequencer: issue, hold off strobe-to-busy, then wait for ready
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_reg     <= H_IDLE;
      wait_reg      <= '0;
      cmd_valid_reg <= 1'b0;
      cmd_op_reg    <= OP_NONE;
      block_reg     <= '0;
      page_reg      <= '0;
      refused_reg   <= 1'b0;
      done_reg      <= 1'b0;
    end else begin
      cmd_valid_reg <= 1'b0;
      refused_reg   <= 1'b0;
      done_reg      <= 1'b0;
      unique case (state_reg)
        H_IDLE: begin
          if (issue && (blocked || over_pp)) begin
            refused_reg <= 1'b1;
          end else if (issue) begin
            cmd_valid_reg <= 1'b1;
            cmd_op_reg    <= req_op;
            block_reg     <= req_block;
            page_reg      <= req_page;
            wait_reg      <= BUSY_CNT_W'(STROBE_TO_BUSY_CYC) + 1'b1;
            state_reg     <= H_WAIT;
          end
        end
        H_WAIT: begin
          // Ready is not trusted until the busy delay has passed
          if (wait_reg != '0) begin
            wait_reg <= wait_reg - 1'b1;  // see R15
          end else begin
            state_reg <= H_BUSY;
          end
        end
        H_BUSY: begin
          if (link.ready) begin
            done_reg  <= 1'b1;
            state_reg <= H_IDLE;
          end
        end
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  // Partial program tracking, cleared by erase or a new page
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pp_reg <= '0;
    end else if (issue && !blocked && !over_pp) begin
      if (req_op == OP_ERASE ||
          req_page != page_reg || req_block != block_reg) begin
        pp_reg <= (req_op == OP_PAGE_PROGRAM || req_op == OP_OTP_PROGRAM)
                  ? PP_CNT_W'(1) : '0;
      end else if (req_op == OP_PAGE_PROGRAM ||
                   req_op == OP_OTP_PROGRAM) begin
        pp_reg <= pp_reg + 1'b1;
      end
    end
  end

  assign link.cmd_valid = cmd_valid_reg;
  assign link.cmd_op    = cmd_op_reg;
  assign link.cmd_block = block_reg;
  assign link.cmd_page  = page_reg;
  assign req_ready      = (state_reg == H_IDLE);
  assign req_refused    = refused_reg;
  assign done           = done_reg;
endmodule
`default_nettype wire

// ==== sim/nand_busy_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module nand_busy_assertions
  import nand_busy_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire op_t  cmd_op,
  input wire logic ready,
  input wire logic sync_mode
);
  // ------------------------------------------------------------
  // Helper state
  // ------------------------------------------------------------
  logic [15:0] cnt_reg;
  op_t         op_reg;
  logic        was_sync_reg;
  logic        prot_reg;
  wire logic   take = cmd_valid && (ready || cmd_op == OP_RESET);

  // Cycles since the last accepted command, saturating when idle
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg      <= '0;
      op_reg       <= OP_NONE;
      was_sync_reg <= 1'b0;
    end else if (take) begin
      cnt_reg      <= '0;
      op_reg       <= cmd_op;
      was_sync_reg <= sync_mode;
    end else if (cnt_reg != 16'hffff) begin
      cnt_reg <= cnt_reg + 16'h1;
    end
  end

  // Protection is one-way, so a sticky flag is enough
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) prot_reg <= 1'b0;
    else if (take && cmd_op == OP_OTP_PROTECT) prot_reg <= 1'b1;
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_take;
    take;
  endsequence
  sequence s_done(op_t op);
    $rose(ready) && op_reg == op;
  endsequence
  // Same end point, qualified by a condition held since the command
  sequence s_done_c(op_t op, logic c);
    $rose(ready) && op_reg == op && c;
  endsequence

  a_busy_on_take: assert property (s_take |=> !ready)
    else $error("ready stayed high after a command");
  a_erase_time: assert property (s_done(OP_ERASE) |-> cnt_reg == ERASE_BUSY_CYC)
    else $error("erase busy length wrong");
  a_cache_rd_time: assert property (s_done(OP_CACHE_READ) |-> cnt_reg == CACHE_READ_CYC)
    else $error("cache read busy length wrong");
  a_feature_time: assert property (s_done(OP_FEATURE) |-> cnt_reg == FEATURE_CYC)
    else $error("feature busy length wrong");
  a_sync_enter: assert property (s_done(OP_MODE_SYNC) |-> cnt_reg == MODE_SWITCH_CYC ##[0:1] sync_mode)
    else $error("mode switch to sync wrong");
  a_sync_leave: assert property (s_done_c(OP_RESET, was_sync_reg) |-> cnt_reg == MODE_SWITCH_CYC ##[0:1] !sync_mode)
    else $error("mode switch back to async wrong");
  a_no_cmd_busy: assert property (cmd_valid |-> ready)
    else $error("command issued while busy");
  a_otp_locked_time: assert property (s_done_c(OP_OTP_PROGRAM, prot_reg) |-> cnt_reg == PROTECTED_OTP_CYC)
    else $error("protected otp busy length wrong");
  a_program_time: assert property (s_done(OP_PAGE_PROGRAM) |-> cnt_reg == PAGE_PROGRAM_CYC)
    else $error("program busy length wrong");
  a_read_time: assert property (s_done(OP_PAGE_READ) |-> cnt_reg == PAGE_READ_CYC)
    else $error("page read busy length wrong");
  a_last_prog_time: assert property (s_done(OP_CACHED_LAST) |-> cnt_reg == FINAL_CACHED_PROGRAM_CYC)
    else $error("final cached program length wrong");
  a_reset_ready: assert property (s_done_c(OP_RESET, !was_sync_reg) |-> cnt_reg == READY_RESET_CYC)
    else $error("reset while ready length wrong");
  a_strobe_gap: assert property (s_take |=> !cmd_valid [*2])
    else $error("command inside strobe to busy gap");
endmodule
`default_nettype wire

// ==== sim/test_nand_array_busy_timing.sv ====
`timescale 1ns/100ps
`default_nettype none
module test_nand_array_busy_timing import nand_busy_pkg::*;;
  typedef struct packed {
    logic       refused;
    logic [1:0] res;
  } note_t;
  logic               clock;
  logic               rst_n;
  logic               req_valid;
  op_t                req_op;
  logic [BLOCK_W-1:0] req_block;
  logic [BLOCK_W-1:0] cur_block;
  logic [PAGE_W-1:0]  req_page;
  logic               req_block_bad;
  logic               req_ready;
  logic               req_refused;
  logic               done;
  logic [BLOCK_W-1:0] mark_bad_block;
  logic               mark_bad_valid;
  logic [BLOCK_W:0]   bad_block_count;
  logic               otp_protected;
  logic               pp_violation;
  note_t              notes[$];
  note_t              exp_n;
  note_t              got_n;
  int                 failures;
  int                 n_tests;
  localparam note_t   OK  = '{refused: 1'b0, res: RES_PASS};
  localparam note_t   NO  = '{refused: 1'b1, res: RES_PASS};

  // ------------------------------------------------------------
  // Both ends joined over one link
  // ------------------------------------------------------------
  nand_busy_if link ();
  nand_busy_host u_nand_busy_host (
    .link (link.host), .clock (clock), .rst_n (rst_n),
    .req_valid (req_valid), .req_op (req_op), .req_block (req_block),
    .req_page (req_page), .req_block_bad (req_block_bad),
    .req_ready (req_ready), .req_refused (req_refused), .done (done));
  nand_busy_device u_nand_busy_device (
    .link (link.device), .clock (clock), .rst_n (rst_n),
    .mark_bad_block (mark_bad_block), .mark_bad_valid (mark_bad_valid),
    .bad_block_count (bad_block_count), .otp_protected (otp_protected),
    .pp_violation (pp_violation));
  nand_busy_assertions u_nand_busy_assertions (
    .clock (clock), .rst_n (rst_n), .cmd_valid (link.cmd_valid),
    .cmd_op (link.cmd_op), .ready (link.ready),
    .sync_mode (link.sync_mode));

  // ------------------------------------------------------------
  // Compare and report
  // ------------------------------------------------------------
  task automatic check_note(input note_t exp, input note_t act);
    n_tests++;
    if (act !== exp) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic check_val(input logic [15:0] exp, input logic [15:0] act);
    n_tests++;
    if (act !== exp) begin
      failures++;
      $display("BAD t=%0t exp=%h got=%h", $time, exp, act);
    end
  endtask
  task automatic final_report();
    $display("comparisons=%0d failures=%0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Bounded wait until the host is idle and every note was matched
  task automatic wait_idle();
    int i;
    i = 0;
    do begin
      @(posedge clock);
      i++;
      if (i > 40000) begin
        failures++;
        final_report();
      end
    end while (req_ready !== 1'b1 || notes.size() != 0);
  endtask
  // One request held for a single edge, where the host samples it
  task automatic issue(input op_t op, input logic [PAGE_W-1:0] pg,
                       input logic bad, input note_t exp);
    notes.push_back(exp);
    req_op        <= op;
    req_block     <= cur_block;
    req_page      <= pg;
    req_block_bad <= bad;
    req_valid     <= 1'b1;
    @(posedge clock);
    req_valid <= 1'b0;
    wait_idle();
  endtask

  // Result watcher; a refusal leaves the old result, so it is masked
  always @(posedge clock) begin
    if (done === 1'b1 || req_refused === 1'b1) begin
      exp_n = (notes.size() != 0) ? notes.pop_front() : '1;
      got_n = {req_refused, link.result};
      if (exp_n.refused === 1'b1) got_n.res = exp_n.res;
      check_note(exp_n, got_n);
    end
  end

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    op_t ops[9];
    ops = '{OP_PAGE_READ, OP_CACHE_READ, OP_FEATURE, OP_PAGE_PROGRAM,
            OP_CACHED_LAST, OP_ERASE, OP_RESET, OP_MODE_SYNC, OP_RESET};
    rst_n = 1'b0;
    req_valid = 1'b0;
    req_op = OP_NONE;
    req_block = '0;
    cur_block = '0;
    req_page = '0;
    req_block_bad = 1'b0;
    mark_bad_block = '0;
    mark_bad_valid = 1'b0;
    failures = 0;
    n_tests = 0;
    void'($urandom(79119));
    repeat (8) @(posedge clock);
    check_val(16'h0022, 16'({link.ready, link.sync_mode, link.result,
                             req_ready, link.cmd_valid}));
    rst_n <= 1'b1;
    // Every operation kind except the OTP ones, back to back, with its mode effect
    foreach (ops[i]) begin
      cur_block = BLOCK_W'($urandom_range(TOTAL_BLOCKS - 1));
      issue(ops[i], PAGE_W'(i), 1'b0, OK);
      check_val(16'(ops[i] == OP_MODE_SYNC), 16'(link.sync_mode));
    end
    // Locked one-time area still goes busy but fails
    issue(OP_OTP_PROGRAM, 7'h14, 1'b0, OK);
    issue(OP_OTP_PROTECT, 7'h0, 1'b0, OK);
    check_val(16'h1, 16'(otp_protected));
    issue(OP_OTP_PROGRAM, 7'h14, 1'b0, '{refused: 1'b0, res: RES_FAIL});
    // Programs and erases of factory-bad blocks never reach the device
    issue(OP_PAGE_PROGRAM, 7'h3, 1'b1, NO);
    issue(OP_ERASE, 7'h0, 1'b1, NO);
    // Fifth partial program of one page is dropped; one block throughout
    cur_block = BLOCK_W'($urandom_range(TOTAL_BLOCKS - 1));
    for (int k = 0; k <= PARTIAL_PROGRAM_LIMIT; k++) begin
      issue(OP_PAGE_PROGRAM, 7'h9, 1'b0,
            (k < PARTIAL_PROGRAM_LIMIT) ? OK : NO);
    end
    check_val(16'h0, 16'(pp_violation));
    // Retire one block more than the spare pool holds
    for (int b = 0; b <= TOTAL_BLOCKS - MIN_VALID_BLOCKS; b++) begin
      mark_bad_block <= BLOCK_W'(100 + b);
      mark_bad_valid <= 1'b1;
      @(posedge clock);
      mark_bad_valid <= 1'b0;
      @(posedge clock);
    end
    @(posedge clock);
    check_val(16'(TOTAL_BLOCKS - MIN_VALID_BLOCKS),
              16'(bad_block_count));
    final_report();
  end
endmodule
`default_nettype wire
